// File: shared/timer_capture_pkg.sv
// Register map, field layout and constants of the timer with input capture.
package timer_capture_pkg;

  // Register indexes; byte address on APB is four times the index.
  localparam logic [7:0] IDX_CAPTURE_ENABLE_FLAGS = 8'h92;
  localparam logic [7:0] IDX_CAPTURE_EDGE_SELECT = 8'h93;
  localparam logic [7:0] IDX_CAPTURE_FILTER_ENABLE = 8'h94;
  localparam logic [7:0] IDX_EXTENDED_IRQ_ENABLE = 8'hA0;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hA1;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'hA2;
  localparam logic [7:0] IDX_TIMER_CONTROL = 8'hC8;
  localparam logic [7:0] IDX_TIMER_MODE = 8'hC9;
  localparam logic [7:0] IDX_RELOAD_LOW = 8'hCA;
  localparam logic [7:0] IDX_RELOAD_HIGH = 8'hCB;
  localparam logic [7:0] IDX_TIMER_COUNT_LOW = 8'hCC;
  localparam logic [7:0] IDX_TIMER_COUNT_HIGH = 8'hCD;
  localparam logic [7:0] IDX_CHANNEL0_RESULT_LOW = 8'hE4;
  localparam logic [7:0] IDX_CHANNEL0_RESULT_HIGH = 8'hE5;
  localparam logic [7:0] IDX_CHANNEL1_RESULT_LOW = 8'hE6;
  localparam logic [7:0] IDX_CHANNEL1_RESULT_HIGH = 8'hE7;
  localparam logic [7:0] IDX_CHANNEL2_RESULT_LOW = 8'hED;
  localparam logic [7:0] IDX_CHANNEL2_RESULT_HIGH = 8'hEE;

  // Field positions.
  localparam int FLAG_LSB = 0;
  localparam int CHAN_EN_LSB = 4;
  localparam int FILTER_EN_LSB = 4;
  localparam int CTRL_CMP_SEL_BIT = 0;
  localparam int CTRL_RUN_BIT = 2;
  localparam int CTRL_TFLAG_BIT = 7;
  localparam int IRQ_CAP_BIT = 2;
  localparam int IRQ_OVF_BIT = 3;
  localparam int IRQ_GLOBAL_BIT = 7;

  // Reset values and the all-ones count.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;

  // Edge select codes.
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  // Timing: glitch filter length in CPU clocks, smallest prescale is 2**2.
  localparam int CLK_PERIOD_NS = 10;
  localparam int FILTER_LEN = 4;
  localparam int PRESCALE_BASE_LOG2 = 2;
  localparam logic [8:0] PRESCALE_BASE = 9'h004;

  typedef enum logic [1:0] {
    MODE_CAPTURE = 2'h0,
    MODE_RELOAD = 2'h1,
    MODE_COMPARE = 2'h3
  } timer_mode_e;

  // Timer mode register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic reload_enable;
    logic [2:0] timer_prescale;
    logic capture_autoclear;
    logic compare_autoclear;
    logic [1:0] reload_trigger_select;
  } timer_mode_s;

endpackage : timer_capture_pkg

// File: verilog/timer2_capture.sv
// Sixteen-bit timer with three input capture channels behind an APB slave.
//
// How it works
// [RQ1] Count is sixteen bits, low and high bytes separately readable and writable.
// [RQ2] Mode: select 0 and reload 0 capture, 0/1 auto-reload, select 1 compare.
// [RQ3] Software halts the timer before touching either count byte.
// [RQ4] Three channels, enables at bits 6..4 of the enable and flag register.
// [RQ5] Filter enable rejects pulses shorter than four clocks before edge detection.
// [RQ6] Edge field: 00 falling, 01 rising, 10 either, 11 reserved.
// [RQ7] Each channel has its own edge detector; all share one count.
// [RQ8] Selected edge on enabled channel copies the count into its result pair.
// [RQ9] Edge on channel n sets flag bit n; only software clears it.
// [RQ10] Capture interrupt when any flag set with capture and global enables.
// [RQ11] Service routine checks the three flags and clears those handled.
// [RQ12] With auto-clear set, count returns to zero right after capture.
// [RQ13] Run bit one counts; zero halts and keeps the present count.
// [RQ14] Prescale code 000 divides by 4, doubling per code up to 512.
// [RQ15] With reload, trigger 00 overflow, 01..11 capture on channel 0..2.
// [RQ16] With auto-clear, a capture only clears the count, no reload.
// [RQ17] Running timer increments once per tick and wraps to zero.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module timer2_capture
  import timer_capture_pkg::*;
#(
  parameter int CHANNELS = 3,
  parameter int FILTER_CYCLES = FILTER_LEN
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Capture inputs, bit n is channel n.
  input wire logic [CHANNELS-1:0] capture_input,
  // Interrupt request, level.
  output logic irq
);

  if (CHANNELS != 3 || FILTER_CYCLES < 2 || FILTER_CYCLES > 7)
  begin : g_bad_param
    $error("timer2_capture: CHANNELS must be 3 and FILTER_CYCLES 2 to 7");
  end

  function automatic logic [8:0] div_last(input logic [2:0] code);
    div_last = 9'((10'(PRESCALE_BASE) << code) - 10'h001);
  endfunction : div_last

  function automatic logic edge_hit(input logic [1:0] sel, input logic rise,
                                    input logic fall);
    case (sel)
      EDGE_FALL: edge_hit = fall;
      EDGE_RISE: edge_hit = rise;
      EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  function automatic logic [7:0] res_idx(input int ch, input logic high);
    case (ch)
      0: res_idx = high ? IDX_CHANNEL0_RESULT_HIGH : IDX_CHANNEL0_RESULT_LOW;
      1: res_idx = high ? IDX_CHANNEL1_RESULT_HIGH : IDX_CHANNEL1_RESULT_LOW;
      default: res_idx = high ? IDX_CHANNEL2_RESULT_HIGH : IDX_CHANNEL2_RESULT_LOW;
    endcase
  endfunction : res_idx

  // Register state.
  logic [2:0] chan_en_q, flag_q, flag_d, filt_en_q;
  logic [5:0] edge_sel_q;
  logic run_q, cmp_sel_q, tflag_q, tflag_d;
  timer_mode_s mode_q;
  logic [15:0] reload_q, count_q, count_d;
  logic [15:0] result_q [3];
  logic [7:0] irq_en_q;
  logic [8:0] div_q;

  // Capture input path per channel.
  logic [2:0] samp_q, filt_q, prev_q, lvl, rise, fall, cap_evt;
  logic [2:0] fcnt_q [3];

  // Bus decode.
  wire [7:0] idx = paddr[9:2];
  wire aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  wire acc = psel & penable;
  logic [7:0] rd_byte;
  logic mapped;
  wire wr = acc & pwrite & pstrb[0] & aligned & mapped;
  wire [7:0] wdata = pwdata[7:0];
  wire wr_flags = wr && (idx == IDX_CAPTURE_ENABLE_FLAGS);
  wire wr_edge = wr && (idx == IDX_CAPTURE_EDGE_SELECT);
  wire wr_filt = wr && (idx == IDX_CAPTURE_FILTER_ENABLE);
  wire wr_irq_en = wr && (idx == IDX_EXTENDED_IRQ_ENABLE);
  wire wr_irq_clr = wr && (idx == IDX_IRQ_CLEAR);
  wire wr_ctrl = wr && (idx == IDX_TIMER_CONTROL);
  wire wr_mode = wr && (idx == IDX_TIMER_MODE);
  wire wr_rl_lo = wr && (idx == IDX_RELOAD_LOW);
  wire wr_rl_hi = wr && (idx == IDX_RELOAD_HIGH);
  wire wr_cnt_lo = wr && (idx == IDX_TIMER_COUNT_LOW); // [RQ1]
  wire wr_cnt_hi = wr && (idx == IDX_TIMER_COUNT_HIGH); // [RQ1]
  wire cnt_wr = wr_cnt_lo | wr_cnt_hi;

  // Zero wait states; unmapped or misaligned addresses answer with an error.
  assign pready = 1'b1;
  assign pslverr = acc & ~(aligned & mapped);

  always_comb
  begin
    mapped = 1'b1;
    rd_byte = RST_BYTE;
    case (idx)
      IDX_CAPTURE_ENABLE_FLAGS: rd_byte = {1'b0, chan_en_q, 1'b0, flag_q};
      IDX_CAPTURE_EDGE_SELECT: rd_byte = {2'h0, edge_sel_q};
      IDX_CAPTURE_FILTER_ENABLE: rd_byte = {1'b0, filt_en_q, 4'h0};
      IDX_EXTENDED_IRQ_ENABLE: rd_byte = irq_en_q;
      IDX_IRQ_STATUS: rd_byte = {4'h0, tflag_q, |flag_q, 2'h0};
      IDX_IRQ_CLEAR: rd_byte = RST_BYTE;
      IDX_TIMER_CONTROL: rd_byte = {tflag_q, 4'h0, run_q, 1'b0, cmp_sel_q};
      IDX_TIMER_MODE: rd_byte = mode_q;
      IDX_RELOAD_LOW: rd_byte = reload_q[7:0];
      IDX_RELOAD_HIGH: rd_byte = reload_q[15:8];
      IDX_TIMER_COUNT_LOW: rd_byte = count_q[7:0]; // [RQ1]
      IDX_TIMER_COUNT_HIGH: rd_byte = count_q[15:8]; // [RQ1]
      IDX_CHANNEL0_RESULT_LOW: rd_byte = result_q[0][7:0];
      IDX_CHANNEL0_RESULT_HIGH: rd_byte = result_q[0][15:8];
      IDX_CHANNEL1_RESULT_LOW: rd_byte = result_q[1][7:0];
      IDX_CHANNEL1_RESULT_HIGH: rd_byte = result_q[1][15:8];
      IDX_CHANNEL2_RESULT_LOW: rd_byte = result_q[2][7:0];
      IDX_CHANNEL2_RESULT_HIGH: rd_byte = result_q[2][15:8];
      default: mapped = 1'b0;
    endcase
  end

  // Read data is taken at the end of the setup cycle and stands through the access cycle.
  // It is a snapshot one cycle old, so a running count may have moved on by the access edge.
  wire rd_setup = psel & ~penable & ~pwrite & aligned;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else
      prdata <= rd_setup ? {24'h000000, rd_byte} : 32'h00000000;
  end

  // Configuration registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chan_en_q <= 3'h0;
      edge_sel_q <= 6'h00;
      filt_en_q <= 3'h0;
      irq_en_q <= RST_BYTE;
      run_q <= 1'b0;
      cmp_sel_q <= 1'b0;
      mode_q <= timer_mode_s'(RST_BYTE);
      reload_q <= RST_WORD;
    end
    else
    begin
      if (wr_flags) chan_en_q <= wdata[CHAN_EN_LSB +: 3]; // [RQ4]
      if (wr_edge) edge_sel_q <= wdata[5:0]; // [RQ6]
      if (wr_filt) filt_en_q <= wdata[FILTER_EN_LSB +: 3]; // [RQ5]
      if (wr_irq_en) irq_en_q <= wdata & 8'h8C;
      if (wr_ctrl) run_q <= wdata[CTRL_RUN_BIT]; // [RQ13]
      if (wr_ctrl) cmp_sel_q <= wdata[CTRL_CMP_SEL_BIT]; // [RQ2]
      if (wr_mode) mode_q <= timer_mode_s'(wdata);
      if (wr_rl_lo) reload_q[7:0] <= wdata;
      if (wr_rl_hi) reload_q[15:8] <= wdata;
    end
  end

  // Input sampling, glitch filter and edge detection, one set per channel.
  for (genvar ch = 0; ch < 3; ch++)
  begin : g_chan
    wire differs = samp_q[ch] ^ filt_q[ch];
    wire settled = differs && (fcnt_q[ch] == 3'(FILTER_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        samp_q[ch] <= 1'b0;
        filt_q[ch] <= 1'b0;
        fcnt_q[ch] <= 3'h0;
        prev_q[ch] <= 1'b0;
      end
      else
      begin
        samp_q[ch] <= capture_input[ch];
        // A level must differ for the full window before it passes.
        fcnt_q[ch] <= (differs && !settled) ? 3'(fcnt_q[ch] + 3'h1) : 3'h0; // [RQ5]
        if (settled) filt_q[ch] <= samp_q[ch]; // [RQ5]
        prev_q[ch] <= lvl[ch];
      end
    end

    assign lvl[ch] = filt_en_q[ch] ? filt_q[ch] : samp_q[ch]; // [RQ5]
    assign rise[ch] = lvl[ch] & ~prev_q[ch]; // [RQ7]
    assign fall[ch] = ~lvl[ch] & prev_q[ch]; // [RQ7]
    assign cap_evt[ch] = chan_en_q[ch]
                         & edge_hit(edge_sel_q[2*ch +: 2], rise[ch], fall[ch]); // [RQ6]

    wire wr_lo = wr && (idx == res_idx(ch, 1'b0));
    wire wr_hi = wr && (idx == res_idx(ch, 1'b1));

    // A capture wins over a software write to the same result register.
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        result_q[ch] <= RST_WORD;
      else if (cap_evt[ch])
        result_q[ch] <= count_q; // [RQ8]
      else if (wr_lo)
        result_q[ch][7:0] <= wdata;
      else if (wr_hi)
        result_q[ch][15:8] <= wdata;
    end
  end

  // Prescaler; it holds its phase while the timer is halted.
  wire [8:0] last = div_last(mode_q.timer_prescale);
  wire tick = run_q && (div_q >= last); // [RQ14]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_q <= 9'h000;
    else if (run_q)
      div_q <= tick ? 9'h000 : 9'(div_q + 9'h001); // [RQ14]
  end

  // Mode and count events.
  wire timer_mode_e tmode = cmp_sel_q ? MODE_COMPARE :
                            (mode_q.reload_enable ? MODE_RELOAD : MODE_CAPTURE); // [RQ2]
  wire ovf_evt = tick && (count_q == COUNT_ALL_ONES);
  wire cmp_evt = (tmode == MODE_COMPARE) && tick && (count_q == reload_q);
  wire [1:0] trig = mode_q.reload_trigger_select;
  wire trig_evt = (trig == 2'h0) ? ovf_evt : cap_evt[2'(trig - 2'h1)]; // [RQ15]
  wire cap_clear = mode_q.capture_autoclear && (|cap_evt); // [RQ12]
  wire cmp_clear = mode_q.compare_autoclear && cmp_evt;
  wire cap_trig = trig != 2'h0;
  wire reload_evt = (tmode == MODE_RELOAD) && trig_evt
                    && !(cap_trig && mode_q.capture_autoclear); // [RQ16]

  // Software byte writes first, then clears, reload and finally the tick.
  assign count_d = wr_cnt_lo ? {count_q[15:8], wdata} :
                   wr_cnt_hi ? {wdata, count_q[7:0]} :
                   (cap_clear || cmp_clear) ? RST_WORD : // [RQ12]
                   reload_evt ? reload_q : // [RQ15]
                   tick ? 16'(count_q + 16'h0001) : count_q; // [RQ17] [RQ13]

  // A new event in the clearing cycle keeps the flag set.
  assign flag_d = cap_evt | (flag_q & ~({3{wr_flags}} & ~wdata[FLAG_LSB +: 3])
                  & ~{3{wr_irq_clr & wdata[IRQ_CAP_BIT]}}); // [RQ9]
  assign tflag_d = ovf_evt | cmp_evt | (tflag_q & ~(wr_irq_clr & wdata[IRQ_OVF_BIT]));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_q <= RST_WORD;
      flag_q <= 3'h0;
      tflag_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      flag_q <= flag_d;
      tflag_q <= tflag_d;
    end
  end

  assign irq = irq_en_q[IRQ_GLOBAL_BIT] & (((|flag_q) & irq_en_q[IRQ_CAP_BIT])
               | (tflag_q & irq_en_q[IRQ_OVF_BIT])); // [RQ10]

  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_quiet;
    !cnt_wr && !(|cap_evt) && !cmp_evt && !reload_evt;
  endsequence

  property p_flag_set;
    cap_evt[0] |=> flag_q[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag 0 not set after capture"); // [RQ9]

  property p_flag_hold;
    flag_q[0] && !wr_flags && !wr_irq_clr |=> flag_q[0];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag 0 dropped by hardware"); // [RQ9]

  property p_latch;
    cap_evt[1] |=> result_q[1] == $past(count_q);
  endproperty
  a_latch: assert property (p_latch) else $error("channel 1 result not the count"); // [RQ8]

  property p_autoclear;
    cap_clear && !cnt_wr |=> count_q == RST_WORD;
  endproperty
  a_autoclear: assert property (p_autoclear) else $error("count not cleared by capture"); // [RQ12]

  property p_halt;
    !run_q && !cmp_sel_q ##0 s_quiet |=> $stable(count_q);
  endproperty
  a_halt: assert property (p_halt) else $error("halted count changed"); // [RQ13]

  property p_irq;
    irq |-> (|flag_q || tflag_q) && irq_en_q[IRQ_GLOBAL_BIT];
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without cause"); // [RQ10]

  property p_irq_cap;
    (|flag_q) && irq_en_q[IRQ_CAP_BIT] && irq_en_q[IRQ_GLOBAL_BIT] |-> irq;
  endproperty
  a_irq_cap: assert property (p_irq_cap) else $error("capture interrupt missing"); // [RQ10]

  property p_filter;
    filt_en_q[0] && $stable(filt_en_q[0]) && $changed(filt_q[0]) |->
      $past(samp_q[0], 2) == filt_q[0] && $past(samp_q[0], 3) == filt_q[0]
      && $past(samp_q[0], 4) == filt_q[0];
  endproperty
  a_filter: assert property (p_filter) else $error("filter passed a short pulse"); // [RQ5]

  property p_rise;
    chan_en_q[2] && edge_sel_q[5:4] == EDGE_RISE |-> cap_evt[2] == rise[2];
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge select wrong"); // [RQ6]

  property p_tick_gap;
    tick |=> !tick [*3];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("prescaler faster than 4"); // [RQ14]

  property p_reload;
    reload_evt && !cnt_wr && !cap_clear && !cmp_clear |=> count_q == $past(reload_q);
  endproperty
  a_reload: assert property (p_reload) else $error("reload value not loaded"); // [RQ15]

  property p_no_reload_on_clear;
    cap_clear && cap_trig |-> !reload_evt;
  endproperty
  a_no_reload_on_clear: assert property (p_no_reload_on_clear) // [RQ16]
    else $error("reload with auto-clear");

  property p_wrap;
    ovf_evt && !cnt_wr && !cap_clear && !reload_evt |=> count_q == RST_WORD;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap"); // [RQ17]

endmodule : timer2_capture

`default_nettype wire

// File: test/capture_source.sv
// Model of the three external capture pins that feed the timer.
`timescale 1ns/1ps
`default_nettype none

module capture_source
(
  // Clock.
  input wire logic pclk,
  // Pins towards the timer.
  output logic [2:0] capture_input
);
  initial capture_input = 3'h0;

  // Toggles one pin, holds it for width clocks, then restores it.
  // A width below four clocks stands for a glitch on the line.
  task automatic pulse(input int ch, input int width);
    @(posedge pclk);
    capture_input[ch] <= ~capture_input[ch];
    repeat (width) @(posedge pclk);
    capture_input[ch] <= ~capture_input[ch];
    repeat (8) @(posedge pclk);
  endtask : pulse
endmodule : capture_source
`default_nettype wire

// File: test/timer2_capture_tb.sv
// Self-checking testbench of the timer with input capture.
`timescale 1ns/1ps
`default_nettype none

module timer2_capture_tb;
  import timer_capture_pkg::*;

  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] capture_input;
  logic irq;
  int err_count;
  int comparisons;
  int cycles;
  logic [7:0] rd;
  logic err;
  logic [7:0] rst_idx [7] = '{8'h92, 8'h93, 8'h94, 8'hCC, 8'hCD, 8'hE4, 8'hE5};

  timer2_capture i_timer2_capture (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_input(capture_input),
    .irq(irq));
  capture_source i_capture_source (.pclk(pclk), .capture_input(capture_input));

  initial pclk = 1'b0;
  always #(CLK_PERIOD_NS / 2) pclk = ~pclk;

  // The whole run needs under a thousand cycles; the ceiling leaves a wide margin.
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      err_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic range_check(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    comparisons++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      err_count++;
      $display("BAD at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask : range_check

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    apb(idx, 1'b1, wd);
  endtask : wr

  task automatic rd_check(input logic [7:0] idx, input logic [7:0] exp);
    apb(idx, 1'b0, 8'h00);
    check(rd, exp);
  endtask : rd_check

  // The irq output follows register writes at the same edge, so look mid-cycle.
  task automatic irq_check(input logic [7:0] exp);
    @(negedge pclk);
    check({7'h00, irq}, exp);
  endtask : irq_check

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    cycles = 0;
    err_count = 0;
    comparisons = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_idx[i]) rd_check(rst_idx[i], 8'h00);
    apb(8'h10, 1'b0, 8'h00);
    check({7'h00, err}, 8'h01);
    check(rd, 8'h00);
    wr(IDX_TIMER_COUNT_LOW, 8'hA5);
    wr(IDX_TIMER_COUNT_HIGH, 8'h5A);
    repeat (20) @(posedge pclk);
    rd_check(IDX_TIMER_COUNT_LOW, 8'hA5);
    rd_check(IDX_TIMER_COUNT_HIGH, 8'h5A);
    wr(IDX_CAPTURE_ENABLE_FLAGS, 8'h70);
    for (int code = 0; code < 4; code++)
      for (int ch = 0; ch < 3; ch++)
      begin
        wr(IDX_CAPTURE_EDGE_SELECT, {2'h0, code[1:0], code[1:0], code[1:0]});
        i_capture_source.pulse(ch, 2);
        rd_check(IDX_CAPTURE_ENABLE_FLAGS,
                 (code == 3) ? 8'h70 : 8'h70 | (8'h01 << ch));
        wr(IDX_CAPTURE_ENABLE_FLAGS, 8'h70);
      end
    wr(IDX_CAPTURE_EDGE_SELECT, 8'h01);
    wr(IDX_CAPTURE_ENABLE_FLAGS, 8'h10);
    wr(IDX_TIMER_COUNT_LOW, 8'h34);
    wr(IDX_TIMER_COUNT_HIGH, 8'h12);
    i_capture_source.pulse(1, 2);
    i_capture_source.pulse(0, 2);
    rd_check(IDX_CHANNEL0_RESULT_LOW, 8'h34);
    rd_check(IDX_CHANNEL0_RESULT_HIGH, 8'h12);
    repeat (30) @(posedge pclk);
    rd_check(IDX_CAPTURE_ENABLE_FLAGS, 8'h11);
    irq_check(8'h00);
    wr(IDX_EXTENDED_IRQ_ENABLE, 8'h84);
    irq_check(8'h01);
    rd_check(IDX_IRQ_STATUS, 8'h04);
    wr(IDX_EXTENDED_IRQ_ENABLE, 8'h04);
    irq_check(8'h00);
    wr(IDX_EXTENDED_IRQ_ENABLE, 8'h84);
    irq_check(8'h01);
    wr(IDX_IRQ_CLEAR, 8'h04);
    irq_check(8'h00);
    rd_check(IDX_CAPTURE_ENABLE_FLAGS, 8'h10);
    wr(IDX_RELOAD_LOW, 8'h9A);
    wr(IDX_RELOAD_HIGH, 8'hBC);
    wr(IDX_TIMER_MODE, 8'h89);
    wr(IDX_TIMER_COUNT_LOW, 8'h78);
    wr(IDX_TIMER_COUNT_HIGH, 8'h56);
    i_capture_source.pulse(0, 2);
    rd_check(IDX_CHANNEL0_RESULT_LOW, 8'h78);
    rd_check(IDX_CHANNEL0_RESULT_HIGH, 8'h56);
    rd_check(IDX_TIMER_COUNT_LOW, 8'h00);
    rd_check(IDX_TIMER_COUNT_HIGH, 8'h00);
    wr(IDX_TIMER_MODE, 8'h81);
    i_capture_source.pulse(0, 2);
    rd_check(IDX_TIMER_COUNT_LOW, 8'h9A);
    rd_check(IDX_TIMER_COUNT_HIGH, 8'hBC);
    wr(IDX_TIMER_MODE, 8'h83);
    wr(IDX_CAPTURE_ENABLE_FLAGS, 8'h70);
    wr(IDX_TIMER_COUNT_LOW, 8'h11);
    i_capture_source.pulse(0, 2);
    rd_check(IDX_TIMER_COUNT_LOW, 8'h11);
    i_capture_source.pulse(2, 2);
    rd_check(IDX_TIMER_COUNT_LOW, 8'h9A);
    wr(IDX_TIMER_CONTROL, 8'h01);
    wr(IDX_TIMER_COUNT_LOW, 8'h11);
    i_capture_source.pulse(2, 2);
    rd_check(IDX_TIMER_COUNT_LOW, 8'h11);
    rd_check(IDX_CHANNEL2_RESULT_LOW, 8'h11);
    wr(IDX_TIMER_CONTROL, 8'h00);
    wr(IDX_TIMER_MODE, 8'h00);
    wr(IDX_CAPTURE_FILTER_ENABLE, 8'h10);
    wr(IDX_CAPTURE_ENABLE_FLAGS, 8'h10);
    i_capture_source.pulse(0, 3);
    rd_check(IDX_CAPTURE_ENABLE_FLAGS, 8'h10);
    i_capture_source.pulse(0, 4);
    rd_check(IDX_CAPTURE_ENABLE_FLAGS, 8'h11);
    wr(IDX_CAPTURE_FILTER_ENABLE, 8'h00);
    wr(IDX_TIMER_COUNT_LOW, 8'hFE);
    wr(IDX_TIMER_COUNT_HIGH, 8'hFF);
    wr(IDX_TIMER_CONTROL, 8'h04);
    repeat (40) @(posedge pclk);
    wr(IDX_TIMER_CONTROL, 8'h00);
    rd_check(IDX_TIMER_COUNT_HIGH, 8'h00);
    apb(IDX_TIMER_COUNT_LOW, 1'b0, 8'h00);
    range_check(rd, 8'h07, 8'h0A);
    rd_check(IDX_TIMER_CONTROL, 8'h80);
    wr(IDX_TIMER_COUNT_LOW, 8'h00);
    wr(IDX_TIMER_MODE, 8'h10);
    wr(IDX_TIMER_CONTROL, 8'h04);
    repeat (80) @(posedge pclk);
    wr(IDX_TIMER_CONTROL, 8'h00);
    apb(IDX_TIMER_COUNT_LOW, 1'b0, 8'h00);
    range_check(rd, 8'h09, 8'h0C);
    stop_test();
  end
endmodule : timer2_capture_tb
`default_nettype wire
